// >>> design/pcid_divider.sv
// Operation
// - One divider per core, fixed eight-cycle computation latency.
// - Results valid from the ninth cycle after the operand write.
// - Status register shows ready once the calculation finished.
// - Signed alias write starts a two's-complement calculation.
// - Unsigned alias write starts an unsigned calculation; last alias decides.
// - Each operand write restarts the calculation, latency counted from it.
// - Operands persist; rewriting one reuses the other stored operand.
// - Quotient and remainder are writable; a write cancels the calculation.
// - Any operand or result write sets the dirty flag.
// - Quotient read clears dirty; other reads leave it unchanged.
// - Every port access completes in one clock cycle.
`timescale 1ns/1ps
module pcid_divider
   import pcid_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic io_sel,
   input wire logic io_write,
   input wire logic [7:0] io_addr,
   input wire logic [31:0] io_wdata,
   output logic [31:0] io_rdata
);
   logic rst_meta_reg;
   logic rst_sync_n_reg;
   logic [31:0] num_reg;
   logic [31:0] den_reg;
   logic sgn_reg;
   logic [31:0] quo_reg;
   logic [31:0] rem_reg;
   logic dirty_reg;
   logic [31:0] rdata_reg;
   logic [31:0] num_next;
   logic [31:0] den_next;
   logic sgn_next;
   logic wr_num_u;
   logic wr_den_u;
   logic wr_num_s;
   logic wr_den_s;
   logic wr_quo;
   logic wr_rem;
   logic op_wr;
   logic res_wr;
   logic rd_quo;
   logic core_busy;
   logic core_done;
   logic [31:0] core_quot;
   logic [31:0] core_rem;
   logic ready;

   // ************************************************************
   // Reset release
   // ************************************************************
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_n_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_n_reg <= rst_meta_reg;
      end
   end

   // ************************************************************
   // Port decode
   // ************************************************************
   assign wr_num_u = io_sel && io_write && (io_addr == OFS_UNSIGNED_NUMERATOR_ALIAS);
   assign wr_den_u = io_sel && io_write && (io_addr == OFS_UNSIGNED_DENOMINATOR_ALIAS);
   assign wr_num_s = io_sel && io_write && (io_addr == OFS_SIGNED_NUMERATOR_ALIAS);
   assign wr_den_s = io_sel && io_write && (io_addr == OFS_SIGNED_DENOMINATOR_ALIAS);
   assign wr_quo = io_sel && io_write && (io_addr == OFS_QUOTIENT);
   assign wr_rem = io_sel && io_write && (io_addr == OFS_REMAINDER);
   assign rd_quo = io_sel && !io_write && (io_addr == OFS_QUOTIENT);
   assign op_wr = wr_num_u || wr_den_u || wr_num_s || wr_den_s;
   assign res_wr = wr_quo || wr_rem;

   assign num_next = (wr_num_u || wr_num_s) ? io_wdata : num_reg;
   assign den_next = (wr_den_u || wr_den_s) ? io_wdata : den_reg;
   assign sgn_next = op_wr ? (wr_num_s || wr_den_s) : sgn_reg;

   always_ff @(posedge clock or negedge rst_sync_n_reg)
   begin
      if (!rst_sync_n_reg)
      begin
         num_reg <= RST_WORD;
         den_reg <= RST_WORD;
         sgn_reg <= 1'b0;
      end
      else
      begin
         num_reg <= num_next;
         den_reg <= den_next;
         sgn_reg <= sgn_next;
      end
   end

   // ************************************************************
   // Iterative engine
   // ************************************************************
   // The engine sees the freshly written operand in the same cycle, so no cycle is lost.
   pcid_iter_core u_core (
      .clock(clock),
      .rst_n(rst_sync_n_reg),
      .start(op_wr),
      .abort(res_wr),
      .is_signed(sgn_next),
      .numerator(num_next),
      .denominator(den_next),
      .busy(core_busy),
      .done(core_done),
      .quot(core_quot),
      .rem(core_rem)
   );

   assign ready = !core_busy;

   // ************************************************************
   // Result registers
   // ************************************************************
   // Load results at finish.
   always_ff @(posedge clock or negedge rst_sync_n_reg)
   begin
      if (!rst_sync_n_reg)
      begin
         quo_reg <= RST_WORD;
         rem_reg <= RST_WORD;
      end
      else if (res_wr)
      begin
         if (wr_quo)
         begin
            quo_reg <= io_wdata;
         end
         if (wr_rem)
         begin
            rem_reg <= io_wdata;
         end
      end
      else if (core_done)
      begin
         quo_reg <= core_quot;
         rem_reg <= core_rem;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n_reg)
   begin
      if (!rst_sync_n_reg)
      begin
         dirty_reg <= 1'b0;
      end
      else if (op_wr || res_wr)
      begin
         dirty_reg <= 1'b1;
      end
      else if (rd_quo)
      begin
         dirty_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n_reg)
   begin
      if (!rst_sync_n_reg)
      begin
         rdata_reg <= RST_WORD;
      end
      else if (io_sel && !io_write)
      begin
         unique case (io_addr)
            OFS_UNSIGNED_NUMERATOR_ALIAS,
            OFS_SIGNED_NUMERATOR_ALIAS: rdata_reg <= num_reg;
            OFS_UNSIGNED_DENOMINATOR_ALIAS,
            OFS_SIGNED_DENOMINATOR_ALIAS: rdata_reg <= den_reg;
            OFS_QUOTIENT: rdata_reg <= quo_reg;
            OFS_REMAINDER: rdata_reg <= rem_reg;
            OFS_DIVIDER_CONTROL_STATUS:
            begin
               rdata_reg <= RST_WORD;
               rdata_reg[CSR_READY_BIT] <= ready;
               rdata_reg[CSR_DIRTY_BIT] <= dirty_reg;
            end
            default: rdata_reg <= RST_WORD;
         endcase
      end
   end

   assign io_rdata = rdata_reg;

   // ************************************************************
   // Checks
   // ************************************************************
   // Sign-extended copies keep the reference division clear of the 32-bit overflow case.
   logic signed [32:0] num_ext;
   logic signed [32:0] den_ext;
   assign num_ext = {num_reg[31], num_reg};
   assign den_ext = {den_reg[31], den_reg};

   a_latency_ready: assert property (@(posedge clock) disable iff (!rst_sync_n_reg)
      op_wr ##1 (!(op_wr || res_wr))[*7] |=> ready)
      else $error("Divider not ready eight cycles after operand write.");

   a_busy_window: assert property (@(posedge clock) disable iff (!rst_sync_n_reg)
      op_wr ##1 !(op_wr || res_wr) |-> !ready)
      else $error("Ready shown while calculation still running.");

   a_unsigned_result: assert property (@(posedge clock) disable iff (!rst_sync_n_reg)
      (op_wr && !sgn_next && den_next != 32'h0000_0000) ##1 (!(op_wr || res_wr))[*7]
      |=> (quo_reg == $past(num_reg, 7) / $past(den_reg, 7)) && (rem_reg == $past(num_reg, 7) % $past(den_reg, 7)))
      else $error("Unsigned result wrong on ninth cycle.");

   a_signed_result: assert property (@(posedge clock) disable iff (!rst_sync_n_reg)
      (op_wr && sgn_next && den_next != 32'h0000_0000) ##1 (!(op_wr || res_wr))[*7]
      |=> (quo_reg == 32'($past(num_ext, 7) / $past(den_ext, 7)))
      && (rem_reg == 32'($past(num_ext, 7) % $past(den_ext, 7))))
      else $error("Signed result not truncated toward zero.");

   a_alias_mode: assert property (@(posedge clock) disable iff (!rst_sync_n_reg)
      op_wr |=> sgn_reg == $past(wr_num_s || wr_den_s))
      else $error("Signedness not taken from last alias written.");

   a_operand_kept: assert property (@(posedge clock) disable iff (!rst_sync_n_reg)
      (wr_den_u || wr_den_s) |=> num_reg == $past(num_reg) && den_reg == $past(io_wdata))
      else $error("Divisor write disturbed stored dividend.");

   a_restore_cancel: assert property (@(posedge clock) disable iff (!rst_sync_n_reg)
      wr_quo && !op_wr |=> ready && quo_reg == $past(io_wdata) ##1 quo_reg == $past(io_wdata, 2))
      else $error("Quotient restore did not cancel calculation.");

   a_dirty_set: assert property (@(posedge clock) disable iff (!rst_sync_n_reg)
      (op_wr || res_wr) |=> dirty_reg)
      else $error("Dirty flag not set by register write.");

   a_dirty_clear: assert property (@(posedge clock) disable iff (!rst_sync_n_reg)
      io_sel && !io_write |=> dirty_reg == ($past(dirty_reg) && !$past(rd_quo)))
      else $error("Dirty flag wrong after read.");

   a_csr_read: assert property (@(posedge clock) disable iff (!rst_sync_n_reg)
      io_sel && !io_write && io_addr == OFS_DIVIDER_CONTROL_STATUS
      |=> io_rdata[CSR_READY_BIT] == $past(ready) && io_rdata[CSR_DIRTY_BIT] == $past(dirty_reg))
      else $error("Status read not answered in one cycle.");
endmodule : pcid_divider

// >>> design/pcid_pkg.sv
package pcid_pkg;
   // ************************************************************
   // Port geometry
   // ************************************************************
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 8;

   // ************************************************************
   // Byte offsets on the single-cycle I/O port
   // ************************************************************
   localparam logic [7:0] OFS_UNSIGNED_NUMERATOR_ALIAS = 8'h60;
   localparam logic [7:0] OFS_UNSIGNED_DENOMINATOR_ALIAS = 8'h64;
   localparam logic [7:0] OFS_SIGNED_NUMERATOR_ALIAS = 8'h68;
   localparam logic [7:0] OFS_SIGNED_DENOMINATOR_ALIAS = 8'h6C;
   localparam logic [7:0] OFS_QUOTIENT = 8'h70;
   localparam logic [7:0] OFS_REMAINDER = 8'h74;
   localparam logic [7:0] OFS_DIVIDER_CONTROL_STATUS = 8'h78;

   // ************************************************************
   // Status fields and reset values
   // ************************************************************
   localparam int unsigned CSR_READY_BIT = 0;
   localparam int unsigned CSR_DIRTY_BIT = 1;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // ************************************************************
   // Iteration timing
   // ************************************************************
   localparam int unsigned LATENCY_CYCLES = 8;
   localparam int unsigned BITS_PER_CYCLE = DATA_W / LATENCY_CYCLES;
   localparam logic [2:0] LAST_STEP = 3'(LATENCY_CYCLES - 1);
endpackage : pcid_pkg

// >>> design/pcid_iter_core.sv
`timescale 1ns/1ps
module pcid_iter_core
   import pcid_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic start,
   input wire logic abort,
   input wire logic is_signed,
   input wire logic [31:0] numerator,
   input wire logic [31:0] denominator,
   output logic busy,
   output logic done,
   output logic [31:0] quot,
   output logic [31:0] rem
);
   logic [2:0] step_reg;
   logic busy_reg;
   logic negq_reg;
   logic negr_reg;
   logic [31:0] part_reg;
   logic [31:0] shq_reg;
   logic [31:0] dmag_reg;
   logic [31:0] part_next;
   logic [31:0] shq_next;
   logic [31:0] nmag;
   logic [31:0] dmag;
   logic [31:0] part_src;
   logic [31:0] shq_src;
   logic [31:0] dsor_src;

   // Magnitudes are taken up front so the loop runs unsigned; signs are fixed on the last step.
   assign nmag = (is_signed && numerator[31]) ? 32'(-numerator) : numerator;
   assign dmag = (is_signed && denominator[31]) ? 32'(-denominator) : denominator;

   // The write edge already retires the first four bits, so the result is stored in time for a read in the ninth cycle.
   assign part_src = start ? RST_WORD : part_reg;
   assign shq_src = start ? nmag : shq_reg;
   assign dsor_src = start ? dmag : dmag_reg;

   // ************************************************************
   // Restoring steps, four quotient bits per clock
   // ************************************************************
   always_comb
   begin
      logic [32:0] trial;
      trial = '0;
      part_next = part_src;
      shq_next = shq_src;
      for (int i = 0; i < BITS_PER_CYCLE; i++)
      begin
         trial = {part_next, shq_next[31]};
         shq_next = {shq_next[30:0], 1'b0};
         if (trial >= {1'b0, dsor_src})
         begin
            trial = 33'(trial - {1'b0, dsor_src});
            shq_next[0] = 1'b1;
         end
         part_next = trial[31:0];
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy_reg <= 1'b0;
         step_reg <= 3'd0;
      end
      else if (start)
      begin
         busy_reg <= 1'b1;
         step_reg <= 3'd1;
      end
      else if (abort || done)
      begin
         busy_reg <= 1'b0;
         step_reg <= 3'd0;
      end
      else if (busy_reg)
      begin
         step_reg <= 3'(step_reg + 3'd1);
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         part_reg <= RST_WORD;
         shq_reg <= RST_WORD;
         dmag_reg <= RST_WORD;
         negq_reg <= 1'b0;
         negr_reg <= 1'b0;
      end
      else if (start)
      begin
         part_reg <= part_next;
         shq_reg <= shq_next;
         dmag_reg <= dmag;
         negq_reg <= is_signed && (numerator[31] ^ denominator[31]);
         negr_reg <= is_signed && numerator[31];
      end
      else if (busy_reg)
      begin
         part_reg <= part_next;
         shq_reg <= shq_next;
      end
   end

   assign done = busy_reg && (step_reg == LAST_STEP) && !start && !abort;
   assign busy = busy_reg;
   assign quot = negq_reg ? 32'(-shq_next) : shq_next;
   assign rem = negr_reg ? 32'(-part_next) : part_next;
endmodule : pcid_iter_core

// >>> test/pcid_core_model.sv
`timescale 1ns/1ps
module pcid_core_model
   import pcid_pkg::*;
(
   input wire logic clock,
   output logic io_sel,
   output logic io_write,
   output logic [7:0] io_addr,
   output logic [31:0] io_wdata,
   input wire logic [31:0] io_rdata
);
   // ************************************************************
   // Core side of the single-cycle port
   // ************************************************************
   initial
   begin
      io_sel = 1'b0;
      io_write = 1'b0;
      io_addr = 8'h00;
      io_wdata = 32'h0000_0000;
   end

   task automatic write_word(input logic [7:0] addr, input logic [31:0] data);
      io_sel <= 1'b1;
      io_write <= 1'b1;
      io_addr <= addr;
      io_wdata <= data;
      @(posedge clock);
   endtask : write_word

   // Idle while busy.
   // Released lines flip so that a stale value can never pass for a held one.
   task automatic settle(input int cycles);
      io_sel <= 1'b0;
      io_write <= ~io_write;
      io_addr <= ~io_addr;
      io_wdata <= ~io_wdata;
      repeat (cycles) @(posedge clock);
   endtask : settle

   task automatic read_word(input logic [7:0] addr, output logic [31:0] data);
      io_sel <= 1'b1;
      io_write <= 1'b0;
      io_addr <= addr;
      io_wdata <= ~io_wdata;
      @(posedge clock);
      settle(1);
      data = io_rdata;
   endtask : read_word
endmodule : pcid_core_model

// >>> test/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import pcid_pkg::*;
;
   localparam longint PERIOD = 4;
   logic clock;
   logic rst_n;
   logic io_sel;
   logic io_write;
   logic [7:0] io_addr;
   logic [31:0] io_wdata;
   logic [31:0] io_rdata;
   int errors;
   int n_checks;
   int seed;
   int gap;
   logic [31:0] m_num;
   logic [31:0] m_den;
   logic [31:0] m_q;
   logic [31:0] m_r;
   logic [31:0] n;
   logic [31:0] d;
   logic m_sgn;
   logic m_dirty;
   logic m_valid;
   longint m_done;

   pcid_divider DUT (.clock(clock), .rst_n(rst_n), .io_sel(io_sel), .io_write(io_write),
      .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata));
   pcid_core_model core (.clock(clock), .io_sel(io_sel), .io_write(io_write),
      .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata));

   // ************************************************************
   // Reference model
   // ************************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] want, input logic [7:0] a);
      n_checks++;
      if (got !== want)
      begin
         errors++;
         $display("[ERR] %0t offset %h got %h want %h", $time, a, got, want);
      end
   endtask : check

   task automatic start_calc(input longint t);
      longint sn;
      longint sd;
      sn = m_sgn ? longint'(signed'(m_num)) : longint'(m_num);
      sd = m_sgn ? longint'(signed'(m_den)) : longint'(m_den);
      m_valid = (m_den != 32'h0000_0000);
      if (m_valid)
      begin
         m_q = 32'(sn / sd);
         m_r = 32'(sn % sd);
      end
      m_done = t + 8 * PERIOD;
   endtask : start_calc

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      core.write_word(a, v);
      case (a)
         OFS_UNSIGNED_NUMERATOR_ALIAS, OFS_SIGNED_NUMERATOR_ALIAS: m_num = v;
         OFS_UNSIGNED_DENOMINATOR_ALIAS, OFS_SIGNED_DENOMINATOR_ALIAS: m_den = v;
         OFS_QUOTIENT: m_q = v;
         OFS_REMAINDER: m_r = v;
         default: return;
      endcase
      m_dirty = 1'b1;
      if (a == OFS_QUOTIENT || a == OFS_REMAINDER)
      begin
         m_valid = 1'b1;
         m_done = longint'($time) + PERIOD;
      end
      else
      begin
         m_sgn = (a == OFS_SIGNED_NUMERATOR_ALIAS) || (a == OFS_SIGNED_DENOMINATOR_ALIAS);
         start_calc(longint'($time));
      end
   endtask : wr

   task automatic rd(input logic [7:0] a);
      logic [31:0] got;
      logic [31:0] want;
      logic ready;
      core.read_word(a, got);
      ready = (longint'($time) - PERIOD) >= m_done;
      want = 32'h0000_0000;
      case (a)
         OFS_DIVIDER_CONTROL_STATUS:
         begin
            want[CSR_READY_BIT] = ready;
            want[CSR_DIRTY_BIT] = m_dirty;
         end
         OFS_QUOTIENT: want = m_q;
         OFS_REMAINDER: want = m_r;
         OFS_UNSIGNED_NUMERATOR_ALIAS, OFS_SIGNED_NUMERATOR_ALIAS: want = m_num;
         OFS_UNSIGNED_DENOMINATOR_ALIAS, OFS_SIGNED_DENOMINATOR_ALIAS: want = m_den;
         default: want = 32'h0000_0000;
      endcase
      // Results in flight are undefined, so only settled ones are compared.
      if ((a != OFS_QUOTIENT && a != OFS_REMAINDER) || (ready && m_valid))
         check(got, want, a);
      if (a == OFS_QUOTIENT)
         m_dirty = 1'b0;
   endtask : rd

   task automatic divide(input bit sn, input bit sd, input logic [31:0] vn, input logic [31:0] vd,
      input bit num_too, input int wait_cycles);
      if (num_too)
         wr(sn ? OFS_SIGNED_NUMERATOR_ALIAS : OFS_UNSIGNED_NUMERATOR_ALIAS, vn);
      wr(sd ? OFS_SIGNED_DENOMINATOR_ALIAS : OFS_UNSIGNED_DENOMINATOR_ALIAS, vd);
      if (wait_cycles > 0)
         core.settle(wait_cycles);
      repeat (wait_cycles < 7 ? 4 : 1) rd(OFS_DIVIDER_CONTROL_STATUS);
      rd(OFS_REMAINDER);
      rd(OFS_QUOTIENT);
      rd(OFS_DIVIDER_CONTROL_STATUS);
   endtask : divide

   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up

   // ************************************************************
   // Stimulus
   // ************************************************************
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   initial
   begin
      #100_000;
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      wrap_up();
   end

   initial
   begin
      errors = 0;
      n_checks = 0;
      seed = 32'hbd32_3ff7;
      m_num = 32'h0000_0000;
      m_den = 32'h0000_0000;
      m_q = 32'h0000_0000;
      m_r = 32'h0000_0000;
      m_sgn = 1'b0;
      m_dirty = 1'b0;
      m_valid = 1'b1;
      m_done = 0;
      rst_n = 1'b0;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      rd(OFS_DIVIDER_CONTROL_STATUS);
      rd(OFS_QUOTIENT);
      $display("test reset values done");
      divide(1'b1, 1'b1, 32'hFFFF_FFF9, 32'h0000_0002, 1'b1, 0);
      divide(1'b0, 1'b1, 32'h0000_0007, 32'hFFFF_FFFE, 1'b1, 7);
      divide(1'b1, 1'b1, 32'h8000_0000, 32'hFFFF_FFFF, 1'b1, 9);
      divide(1'b1, 1'b0, 32'h8000_0000, 32'hFFFF_FFFF, 1'b1, 3);
      divide(1'b0, 1'b0, 32'hFFFF_FFFF, 32'h0000_0003, 1'b1, 7);
      divide(1'b0, 1'b1, 32'h0000_0000, 32'hFFFF_FFFD, 1'b0, 2);
      $display("test directed divides done");
      repeat (150)
      begin
         n = $random(seed);
         d = $random(seed);
         d = d >> ($unsigned($random(seed)) % 32);
         if (d == 32'h0000_0000)
            d = 32'h0000_0001;
         gap = $unsigned($random(seed)) % 10;
         divide($random(seed), $random(seed), n, d, ($random(seed) & 3) != 0, gap);
      end
      $display("test random divides done");
      wr(OFS_SIGNED_NUMERATOR_ALIAS, 32'h0000_0064);
      wr(OFS_SIGNED_DENOMINATOR_ALIAS, 32'h0000_0007);
      core.settle(3);
      wr(OFS_UNSIGNED_DENOMINATOR_ALIAS, 32'h0000_0009);
      core.settle(5);
      rd(OFS_DIVIDER_CONTROL_STATUS);
      rd(OFS_REMAINDER);
      rd(OFS_QUOTIENT);
      $display("test restart done");
      wr(OFS_UNSIGNED_DENOMINATOR_ALIAS, 32'h0000_0005);
      wr(OFS_REMAINDER, 32'h1234_5678);
      wr(OFS_QUOTIENT, 32'h9ABC_DEF0);
      rd(OFS_DIVIDER_CONTROL_STATUS);
      rd(OFS_REMAINDER);
      rd(OFS_DIVIDER_CONTROL_STATUS);
      rd(OFS_QUOTIENT);
      rd(OFS_DIVIDER_CONTROL_STATUS);
      wr(OFS_DIVIDER_CONTROL_STATUS, 32'hFFFF_FFFF);
      wr(8'h7C, 32'hFFFF_FFFF);
      rd(OFS_DIVIDER_CONTROL_STATUS);
      rd(8'h7C);
      rd(OFS_UNSIGNED_NUMERATOR_ALIAS);
      rd(OFS_SIGNED_DENOMINATOR_ALIAS);
      $display("test restore and status done");
      wrap_up();
   end
endmodule : tb_top
